// File: src/rpg_core.sv
/*
  Enable, disable and power-good control for two linear regulators and three converters, with an AXI4-Lite register slave.
  Assumes analog comparator and pushbutton state inputs come from outside the clock domain.
*/
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "rpg_map.svh"

// Operation
// (R1) Host writes one to a linear enable bit to switch that regulator on.
// (R2) Linear regulator off on zero bit, logic supply low, or power-down state.
// (R3) System supply lockout keeps linear regulators off, enable requests ignored.
// (R4) Disabled linear regulator powers down and turns on its output pull-down.
// (R5) Separate read-only power-good flag per linear regulator, host readable.
// (R6) Linear good flags captured on own read address, not continuously.
// (R7) Grounded feedback: enable bit connects output through current limit, clear disconnects.
// (R8) One burst select bit per converter, three bits, independent.
// (R9) All three converters enabled and disabled together by pushbutton logic.
// (R10) System supply lockout forces all converters off.
// (R11) Converter good only after all enabled, in regulation, and 230ms elapsed.
// (R12) Converter good pin is open-drain; outside pull-up makes release read high.
// (R13) Higher sensed input above 6V pulls pass-gate drive low.
// (R14) Converters shut down in power-down, power-off or hard-reset states.
// (R15) Soft-start of 500us on each enable, not on mode change.
// (R16) Converter good drops at once on disable or loss, delay restarts.
module rpg_core import rpg_pkg::*; #(
  parameter int unsigned GOOD_DELAY_CYC = `RPG_GOOD_DELAY_CYC
) (
  input  wire logic          clk_sys,               // 100 MHz clock
  input  wire logic          resetn,                // Async reset, active low
  input  wire logic [11:0]   s_axi_awaddr,          // Write address
  input  wire logic          s_axi_awvalid,         // Write address valid
  output logic               s_axi_awready,         // Write address ready
  input  wire logic [31:0]   s_axi_wdata,           // Write data
  input  wire logic [3:0]    s_axi_wstrb,           // Write strobes
  input  wire logic          s_axi_wvalid,          // Write data valid
  output logic               s_axi_wready,          // Write data ready
  output logic [1:0]         s_axi_bresp,           // Write response
  output logic               s_axi_bvalid,          // Write response valid
  input  wire logic          s_axi_bready,          // Write response ready
  input  wire logic [11:0]   s_axi_araddr,          // Read address
  input  wire logic          s_axi_arvalid,         // Read address valid
  output logic               s_axi_arready,         // Read address ready
  output logic [31:0]        s_axi_rdata,           // Read data
  output logic [1:0]         s_axi_rresp,           // Read response
  output logic               s_axi_rvalid,          // Read data valid
  input  wire logic          s_axi_rready,          // Read data ready
  input  wire logic [1:0]    pb_state,              // Pushbutton state, rpg_pb_state_t code
  input  wire logic          system_supply_lockout, // High while system supply below threshold
  input  wire logic          logic_supply_low,      // High while logic supply below threshold
  input  wire logic [1:0]    linear_reg_cmp_good,   // Linear regulator good comparators
  input  wire logic [2:0]    converter_cmp_good,    // Converters at 92% of regulation
  input  wire logic          overvoltage_sense_input, // High when higher input above 6V
  output logic               linear_reg_one_on,     // Linear regulator 1 run
  output logic               linear_reg_two_on,     // Linear regulator 2 run
  output logic [1:0]         linear_reg_pulldown,   // Output pull-downs
  output logic               converters_on,         // Common converter enable
  output logic [2:0]         converter_burst,       // Burst select per converter
  output logic               converter_softstart,   // Soft-start ramp active
  output logic               converters_good_out,   // Open-drain output level, always 0
  output logic               converters_good_oe,    // Pull low while high
  output logic               overvoltage_pass_gate_drive, // Pass-gate drive, low isolates
  output logic               irq                    // Level interrupt
);
  localparam int unsigned SS_CYC = `RPG_SOFTSTART_CYC;

  // Two-flop synchronisers for all analog and pin inputs
  localparam int SYN_W = 10;
  logic [SYN_W-1:0] syn1_reg, syn2_reg, syn_in;
  assign syn_in = {pb_state, system_supply_lockout, logic_supply_low, linear_reg_cmp_good,
                   converter_cmp_good, overvoltage_sense_input};
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      syn1_reg <= {RPG_PB_POWER_OFF, 8'h00}; // Powered off, no false start
      syn2_reg <= {RPG_PB_POWER_OFF, 8'h00};
    end else begin
      syn1_reg <= syn_in;
      syn2_reg <= syn1_reg;
    end
  end
  rpg_pb_state_t pb_s;
  logic       sys_lock_s, logic_low_s, ov_s;
  logic [1:0] lr_cmp_s;
  logic [2:0] cv_cmp_s;
  assign pb_s        = rpg_pb_state_t'(syn2_reg[9:8]);
  assign sys_lock_s  = syn2_reg[7];
  assign logic_low_s = syn2_reg[6];
  assign lr_cmp_s    = syn2_reg[5:4];
  assign cv_cmp_s    = syn2_reg[3:1];
  assign ov_s        = syn2_reg[0];

  // Register state
  logic [31:0] ctrl_reg, ctrl_next;
  logic [1:0]  lr_good_reg, lr_good_next;
  logic [`RPG_EV_WIDTH-1:0] ev_reg, ev_next, mask_reg, mask_next;
  logic        aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
  logic [11:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0]  wstrb_reg, wstrb_next;
  logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [`RPG_EV_WIDTH-1:0] ev_set;
  logic        do_write, do_read;

  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign do_read  = s_axi_arvalid && s_axi_arready;
  assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction : apply_strb

  always_comb begin
    logic [31:0] wv;
    wv = apply_strb(32'h0000_0000, wdata_reg, wstrb_reg);
    aw_hold_next = aw_hold_reg;
    w_hold_next  = w_hold_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg && !s_axi_bready;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg && !s_axi_rready;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    ctrl_next    = ctrl_reg;
    mask_next    = mask_reg;
    lr_good_next = lr_good_reg;
    ev_next      = ev_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (do_write) begin
      aw_hold_next = 1'b0;
      w_hold_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = 2'b00;
      unique case (awaddr_reg)
        `RPG_CTRL_OFFS:   ctrl_next = apply_strb(ctrl_reg, wdata_reg, wstrb_reg) & `RPG_CTRL_MASK; // R1 R8
        `RPG_EVENT_OFFS:  ev_next   = ev_reg & ~wv[`RPG_EV_WIDTH-1:0];
        `RPG_MASK_OFFS:   if (wstrb_reg[0]) mask_next = wdata_reg[`RPG_EV_WIDTH-1:0];
        `RPG_STATUS_OFFS: bresp_next = 2'b10;
        default:          bresp_next = 2'b10;
      endcase
    end
    ev_next = ev_next | ev_set;
    if (do_read) begin
      rvalid_next = 1'b1;
      rresp_next  = 2'b00;
      rdata_next  = 32'h0000_0000;
      unique case (s_axi_araddr)
        `RPG_CTRL_OFFS:   rdata_next = ctrl_reg;
        `RPG_STATUS_OFFS: begin
          lr_good_next = lr_cmp_s;                                   // R6
          rdata_next   = {24'h000000, converters_good_oe ? 1'b0 : 1'b1, !ov_s, sys_lock_s,
                          logic_low_s, 2'b00, lr_cmp_s};             // R5
        end
        `RPG_EVENT_OFFS:  rdata_next = {28'h0000000, ev_reg};
        `RPG_MASK_OFFS:   rdata_next = {28'h0000000, mask_reg};
        default:          rresp_next = 2'b10;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= 12'h000;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'b00;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= 2'b00;
      rdata_reg   <= 32'h0000_0000;
      ctrl_reg    <= `RPG_CTRL_RESET;
      mask_reg    <= '0;
      lr_good_reg <= 2'b00;
      ev_reg      <= '0;
    end else begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg  <= w_hold_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
      ctrl_reg    <= ctrl_next;
      mask_reg    <= mask_next;
      lr_good_reg <= lr_good_next;
      ev_reg      <= ev_next;
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp  = rresp_reg;
  assign s_axi_rdata  = rdata_reg;

  // Regulator drive; all outputs registered
  rpg_drive_t drv_reg, drv_next;
  logic conv_allow, conv_was_reg, conv_was_next, lin_block, ov_reg, ov_next;
  logic [$clog2(SS_CYC+1)-1:0] ss_cnt_reg, ss_cnt_next;
  logic linear_reg_one_enable, linear_reg_two_enable;
  logic [2:0] burst_bits;
  assign linear_reg_one_enable = ctrl_reg[`RPG_CTRL_LR1_EN_BIT];
  assign linear_reg_two_enable = ctrl_reg[`RPG_CTRL_LR2_EN_BIT];
  assign burst_bits            = ctrl_reg[`RPG_CTRL_BURST_LSB +: 3];
  assign lin_block  = sys_lock_s || logic_low_s || (pb_s == RPG_PB_POWER_DOWN);  // R2 R3
  assign conv_allow = !sys_lock_s && (pb_s == RPG_PB_ON);                        // R9 R10 R14

  always_comb begin
    drv_next          = drv_reg;
    drv_next.lr1_en   = linear_reg_one_enable && !lin_block;   // R1 R2 R3 R7
    drv_next.lr2_en   = linear_reg_two_enable && !lin_block;   // R1 R2 R3 R7
    drv_next.lr1_pull = !drv_next.lr1_en;                       // R4
    drv_next.lr2_pull = !drv_next.lr2_en;                       // R4
    drv_next.conv_en  = conv_allow;                             // R9
    drv_next.burst    = burst_bits;                             // R8
    conv_was_next     = conv_allow;
    ss_cnt_next       = ss_cnt_reg;
    if (!conv_allow) begin
      ss_cnt_next = '0;
    end else if (!conv_was_reg) begin
      ss_cnt_next = ($clog2(SS_CYC+1))'(SS_CYC);                // R15
    end else if (ss_cnt_reg != '0) begin
      ss_cnt_next = ss_cnt_reg - 1'b1;
    end
    drv_next.softstart = (ss_cnt_next != '0);                   // R15
    ov_next = ov_s;                                             // R13
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      drv_reg      <= '{lr1_pull: 1'b1, lr2_pull: 1'b1, default: '0};
      conv_was_reg <= 1'b0;
      ss_cnt_reg   <= '0;
      ov_reg       <= 1'b1;
    end else begin
      drv_reg      <= drv_next;
      conv_was_reg <= conv_was_next;
      ss_cnt_reg   <= ss_cnt_next;
      ov_reg       <= ov_next;
    end
  end
  assign linear_reg_one_on   = drv_reg.lr1_en;
  assign linear_reg_two_on   = drv_reg.lr2_en;
  assign linear_reg_pulldown = {drv_reg.lr2_pull, drv_reg.lr1_pull};
  assign converters_on       = drv_reg.conv_en;
  assign converter_burst     = drv_reg.burst;
  assign converter_softstart = drv_reg.softstart;
  assign overvoltage_pass_gate_drive = !ov_reg;                 // R13

  // Converter good delay
  rpg_good_state_t gst_reg, gst_next;
  logic [31:0] gcnt_reg, gcnt_next;
  logic all_good;
  assign all_good = drv_reg.conv_en && (&cv_cmp_s);
  always_comb begin
    gst_next  = gst_reg;
    gcnt_next = gcnt_reg;
    unique case (gst_reg)
      RPG_GOOD_IDLE: if (all_good) begin
        gst_next  = RPG_GOOD_WAIT;
        gcnt_next = 32'h0000_0001;
      end
      RPG_GOOD_WAIT: begin
        if (!all_good) gst_next = RPG_GOOD_IDLE;                // R16
        else if (gcnt_reg >= GOOD_DELAY_CYC) gst_next = RPG_GOOD_HELD; // R11
        else gcnt_next = gcnt_reg + 32'h0000_0001;
      end
      RPG_GOOD_HELD: if (!all_good) gst_next = RPG_GOOD_IDLE;   // R16
      default: gst_next = RPG_GOOD_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gst_reg  <= RPG_GOOD_IDLE;
      gcnt_reg <= 32'h0000_0000;
    end else begin
      gst_reg  <= gst_next;
      gcnt_reg <= gcnt_next;
    end
  end
  assign converters_good_out = 1'b0;                            // R12
  assign converters_good_oe  = (gst_reg != RPG_GOOD_HELD);      // R12

  assign ev_set[`RPG_EV_SYS_LOCK]  = sys_lock_s;
  assign ev_set[`RPG_EV_LOGIC_LOW] = logic_low_s;
  assign ev_set[`RPG_EV_OVERVOLT]  = ov_s;
  assign ev_set[`RPG_EV_CONV_GOOD] = (gst_next == RPG_GOOD_HELD) && (gst_reg != RPG_GOOD_HELD);
  assign irq = |(ev_reg & mask_reg);

  chk_lin_off_lock: assert property (@(posedge clk_sys) disable iff (!resetn)
    lin_block |=> !linear_reg_one_on && !linear_reg_two_on) else $error("linear on while blocked"); // R2
  chk_lin_lockout: assert property (@(posedge clk_sys) disable iff (!resetn)
    sys_lock_s && linear_reg_one_enable |=> !linear_reg_one_on) else $error("lockout ignored"); // R3
  chk_pull_down: assert property (@(posedge clk_sys) disable iff (!resetn)
    linear_reg_pulldown == ~{linear_reg_two_on, linear_reg_one_on}) else $error("pull-down wrong"); // R4
  chk_lin_enable: assert property (@(posedge clk_sys) disable iff (!resetn)
    linear_reg_one_enable && !lin_block |=> linear_reg_one_on) else $error("enable not applied"); // R1
  chk_good_sample: assert property (@(posedge clk_sys) disable iff (!resetn)
    !(do_read && s_axi_araddr == `RPG_STATUS_OFFS) |=> lr_good_reg == $past(lr_good_reg))
    else $error("good flags moved"); // R6
  chk_conv_lock: assert property (@(posedge clk_sys) disable iff (!resetn)
    sys_lock_s |=> !converters_on) else $error("converters on in lockout"); // R10
  chk_conv_pb: assert property (@(posedge clk_sys) disable iff (!resetn)
    pb_s != RPG_PB_ON |=> !converters_on) else $error("converters on in shutdown"); // R14
  chk_burst_copy: assert property (@(posedge clk_sys) disable iff (!resetn)
    ##1 converter_burst == $past(burst_bits)) else $error("burst not followed"); // R8
  chk_good_drop: assert property (@(posedge clk_sys) disable iff (!resetn)
    !all_good |=> converters_good_oe) else $error("good held after loss"); // R16
  chk_good_delay: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(all_good) |-> converters_good_oe [*8]) else $error("good too early"); // R11
  chk_soft_start: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(converters_on) |-> converter_softstart) else $error("no soft-start"); // R15
  chk_ov_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
    ov_s |=> !overvoltage_pass_gate_drive) else $error("gate not pulled"); // R13
  cov_conv_good: cover property (@(posedge clk_sys) disable iff (!resetn) $fell(converters_good_oe));
  cov_lin_on: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(linear_reg_one_on));
  cov_irq: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(irq));
endmodule : rpg_core

// File: include/rpg_map.svh
/*
  Register offsets, field positions, reset values and timing counts for the regulator enable and power-good block.
  Assumes a 100 MHz system clock.
*/
`ifndef RPG_MAP_SVH
`define RPG_MAP_SVH

`define RPG_CTRL_OFFS        12'h000
`define RPG_STATUS_OFFS      12'h004
`define RPG_EVENT_OFFS       12'h008
`define RPG_MASK_OFFS        12'h00C

`define RPG_CTRL_LR1_EN_BIT  0
`define RPG_CTRL_LR2_EN_BIT  1
`define RPG_CTRL_BURST_LSB   4
`define RPG_CTRL_RESET       32'h0000_0000
`define RPG_CTRL_MASK        32'h0000_0073

`define RPG_EV_WIDTH         4
`define RPG_EV_SYS_LOCK      0
`define RPG_EV_LOGIC_LOW     1
`define RPG_EV_OVERVOLT      2
`define RPG_EV_CONV_GOOD     3

`define RPG_CLK_MHZ          100
`define RPG_GOOD_DELAY_MS    230
`define RPG_GOOD_DELAY_CYC   (`RPG_GOOD_DELAY_MS * 1000 * `RPG_CLK_MHZ)
`define RPG_SOFTSTART_US     500
`define RPG_SOFTSTART_CYC    (`RPG_SOFTSTART_US * `RPG_CLK_MHZ)

`endif

// File: include/rpg_pkg.sv
/*
  Types for the regulator enable and power-good block.
  Assumes nothing beyond the map header.
*/
package rpg_pkg;
  typedef enum logic [1:0] {
    RPG_PB_ON,
    RPG_PB_POWER_DOWN,
    RPG_PB_POWER_OFF,
    RPG_PB_HARD_RESET
  } rpg_pb_state_t;

  typedef enum logic [1:0] {
    RPG_GOOD_IDLE,
    RPG_GOOD_WAIT,
    RPG_GOOD_HELD
  } rpg_good_state_t;

  typedef struct packed {
    logic       lr1_en;
    logic       lr2_en;
    logic       lr1_pull;
    logic       lr2_pull;
    logic       conv_en;
    logic [2:0] burst;
    logic       softstart;
  } rpg_drive_t;
endpackage : rpg_pkg

// File: test/rpg_far_model.sv
/*
  Far side of the regulator block: pushbutton state level, regulator
  comparators and the pull-up on the open-drain good pin.
  Assumes the core clock and reset of the bench.
*/
`timescale 1ns/1ps
module rpg_far_model import rpg_pkg::*; #(
  parameter int RAMP_CYC = 8
) (
  input  wire logic       clk_sys,   // Core clock
  input  wire logic       resetn,    // Async reset, active low
  input  wire logic [1:0] pb_req,    // Requested pushbutton state
  input  wire logic [2:0] conv_fault, // Converters pushed out of regulation
  input  wire logic       conv_on,   // Common converter enable
  input  wire logic [1:0] lin_on,    // Linear regulator runs
  input  wire logic       good_out,  // Open-drain level
  input  wire logic       good_oe,   // Open-drain pull low
  output logic [1:0]      pb_state,  // Pushbutton state code
  output logic [2:0]      conv_good, // Converter comparators
  output logic [1:0]      lin_good,  // Linear comparators
  output wire             good_pin   // Resolved pin level
);
  int ramp_reg;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pb_state <= RPG_PB_POWER_OFF;
      ramp_reg <= 0;
    end else begin
      pb_state <= pb_req;
      ramp_reg <= !conv_on ? 0 : (ramp_reg < RAMP_CYC ? ramp_reg + 1 : ramp_reg);
    end
  end
  // Outputs climb to 92% slowly but lose it at once
  assign conv_good = (conv_on && ramp_reg == RAMP_CYC) ? ~conv_fault : 3'h0;
  assign lin_good = lin_on;
  // Outside pull-up: a released pin reads high
  assign good_pin = good_oe ? good_out : 1'h1;
endmodule : rpg_far_model

// File: test/tb.sv
/*
  Self-checking bench for the regulator enable and power-good block.
  Assumes the design package and the far-side model are compiled first.
*/
`timescale 1ns/1ps
module tb import rpg_pkg::*; ;
  logic clk_sys = 1'h0, resetn = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, pb_state, linear_reg_cmp_good, linear_reg_pulldown;
  logic [1:0] pb_req = RPG_PB_POWER_OFF;
  logic system_supply_lockout = 1'h0, logic_supply_low = 1'h0, overvoltage_sense_input = 1'h0;
  logic [2:0] converter_cmp_good, converter_burst, conv_fault = 3'h0;
  logic linear_reg_one_on, linear_reg_two_on, converters_on, converter_softstart;
  logic converters_good_out, converters_good_oe, overvoltage_pass_gate_drive, irq;
  wire good_pin;
  int err_count = 0, checks = 0, cyc_count = 0, n;

  rpg_core #(.GOOD_DELAY_CYC(20)) dut (.clk_sys, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pb_state, .system_supply_lockout, .logic_supply_low, .linear_reg_cmp_good, .converter_cmp_good,
    .overvoltage_sense_input, .linear_reg_one_on, .linear_reg_two_on, .linear_reg_pulldown, .converters_on,
    .converter_burst, .converter_softstart, .converters_good_out, .converters_good_oe,
    .overvoltage_pass_gate_drive, .irq);
  rpg_far_model far (.clk_sys, .resetn, .pb_req, .conv_fault, .conv_on(converters_on),
    .lin_on({linear_reg_two_on, linear_reg_one_on}), .good_out(converters_good_out),
    .good_oe(converters_good_oe), .pb_state, .conv_good(converter_cmp_good), .lin_good(linear_reg_cmp_good),
    .good_pin);

  initial forever #5 clk_sys = ~clk_sys;

  task automatic complete_run;
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run

  always @(posedge clk_sys) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 90000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Ends mid-cycle so registered outputs have settled
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : cyc

  // Ready sampled at the falling edge is what the next rising edge sees
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, b_ok;
    b_ok = 1'h0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!b_ok) begin
      @(negedge clk_sys);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      b_ok = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, r_ok;
    r_ok = 1'h0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!r_ok) begin
      @(negedge clk_sys);
      ta = s_axi_arvalid && s_axi_arready;
      r_ok = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_sys);
      if (ta) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
  endtask : axi_rd

  task automatic lin_is(input string w, input logic [3:0] e);
    cyc(6);
    check(w, {linear_reg_two_on, linear_reg_one_on, linear_reg_pulldown}, e);
  endtask : lin_is

  task automatic t_reset;
    cyc(1);
    lin_is("lin reset", 4'h3);
    check("conv reset", converters_on, 1'h0);
    check("oe reset", converters_good_oe, 1'h1);
    axi_rd(12'h000, rd, resp);
    check("ctrl reset", rd, 32'h0);
    axi_rd(12'h010, rd, resp);
    check("unmapped", resp, 2'h2);
  endtask : t_reset

  task automatic t_linear;
    axi_wr(12'h000, 32'h1, resp);
    lin_is("lin one", 4'h6);
    axi_rd(12'h004, rd, resp);
    check("flags one", rd[1:0], 2'h1);
    axi_wr(12'h000, 32'h2, resp);
    lin_is("lin two", 4'h9);
    axi_wr(12'h000, 32'h3, resp);
    lin_is("lin both", 4'hC);
    axi_rd(12'h004, rd, resp);
    check("flags both", rd[1:0], 2'h3);
    axi_wr(12'h004, 32'h0, resp);
    check("status ro", resp, 2'h2);
    @(posedge clk_sys) logic_supply_low <= 1'h1;
    lin_is("logic low", 4'h3);
    @(posedge clk_sys) logic_supply_low <= 1'h0;
    lin_is("logic back", 4'hC);
    @(posedge clk_sys) pb_req <= RPG_PB_POWER_DOWN;
    lin_is("pb down", 4'h3);
    @(posedge clk_sys) pb_req <= RPG_PB_POWER_OFF;
    lin_is("pb off", 4'hC);
    @(posedge clk_sys) system_supply_lockout <= 1'h1;
    lin_is("lockout", 4'h3);
    axi_wr(12'h000, 32'h3, resp);
    lin_is("lockout write", 4'h3);
    @(posedge clk_sys) system_supply_lockout <= 1'h0;
    lin_is("lockout gone", 4'hC);
    axi_wr(12'h000, 32'h0, resp);
    lin_is("lin cleared", 4'h3);
  endtask : t_linear

  task automatic t_conv;
    axi_wr(12'h00C, 32'h8, resp);
    @(posedge clk_sys) pb_req <= RPG_PB_ON;
    n = 0;
    while (converter_softstart !== 1'h1 && n < 20) begin @(negedge clk_sys); n++; end
    check("conv on", converters_on, 1'h1);
    n = 0;
    while (converter_softstart !== 1'h0 && n < 60000) begin @(negedge clk_sys); n++; end
    check("ramp length", 32'(n >= 49998 && n <= 50002), 32'h1);
    check("good held", good_pin, 1'h1);
    for (int i = 0; i < 3; i++) begin
      axi_wr(12'h000, 32'h10 << i, resp);
      cyc(4);
      check("burst", converter_burst, 3'h1 << i);
      check("no ramp", converter_softstart, 1'h0);
    end
    @(posedge clk_sys) conv_fault <= 3'h2;
    cyc(5);
    check("good lost", good_pin, 1'h0);
    check("od level", converters_good_out, 1'h0);
    axi_wr(12'h008, 32'hF, resp);
    cyc(2);
    check("irq clear", irq, 1'h0);
    @(posedge clk_sys) conv_fault <= 3'h0;
    n = 0;
    while (good_pin !== 1'h1 && n < 100) begin @(negedge clk_sys); n++; end
    check("good delay", 32'(n >= 20 && n <= 30), 32'h1);
    check("irq good", irq, 1'h1);
    for (int st = 1; st < 4; st++) begin
      @(posedge clk_sys) pb_req <= 2'(st);
      cyc(6);
      check("pb shut", converters_on, 1'h0);
      check("pb good", good_pin, 1'h0);
      @(posedge clk_sys) pb_req <= RPG_PB_ON;
      cyc(6);
      check("pb up", converters_on, 1'h1);
    end
    @(posedge clk_sys) system_supply_lockout <= 1'h1;
    cyc(6);
    check("conv lockout", converters_on, 1'h0);
    @(posedge clk_sys) system_supply_lockout <= 1'h0;
  endtask : t_conv

  task automatic t_ovp;
    axi_wr(12'h00C, 32'h4, resp);
    axi_wr(12'h008, 32'hF, resp);
    cyc(2);
    check("gate on", overvoltage_pass_gate_drive, 1'h1);
    @(posedge clk_sys) overvoltage_sense_input <= 1'h1;
    cyc(6);
    check("gate cut", overvoltage_pass_gate_drive, 1'h0);
    check("irq ov", irq, 1'h1);
    axi_wr(12'h00C, 32'h0, resp);
    cyc(2);
    check("irq masked", irq, 1'h0);
    @(posedge clk_sys) overvoltage_sense_input <= 1'h0;
    cyc(6);
    check("gate back", overvoltage_pass_gate_drive, 1'h1);
    axi_wr(12'h008, 32'h4, resp);
    axi_rd(12'h008, rd, resp);
    check("event w1c", rd[2], 1'h0);
  endtask : t_ovp

  initial begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'h1;
    t_reset();
    t_linear();
    t_conv();
    t_ovp();
    complete_run();
  end
endmodule : tb
